// File: design/scc_map.vh
// constants and register map of the sleep and reset cause controller
//
// How it works
// - a sleep-enabled peripheral keeps its clock while the core sleeps and may wake it.
// - with sleep gating off the sleep enables are kept but ignored, so all run-enabled peripherals run.
// - the core stays asleep until a wake condition or a device reset returns it to run mode.
// - a software reset resets core and peripherals and sets all registers except the cause flags to defaults.
// - a software reset keeps the cause register and adds the software flag.
// - each cause flag is sticky until software clears it or an external reset occurs.
// - five separate cause flags are read back together as one bit field.
// - software clears any chosen subset of cause flags and the rest stay untouched.
// - peripherals start disabled and a disabled one neither runs nor answers accesses.
// - a peripheral is usable five cycles after its enable, and access before that faults.
`ifndef SCC_MAP_VH
`define SCC_MAP_VH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define SCC_OFF_RUN_EN     8'h00
`define SCC_OFF_SLEEP_EN   8'h04
`define SCC_OFF_CTRL       8'h08
`define SCC_OFF_STATE      8'h0c
`define SCC_OFF_READY      8'h10
`define SCC_OFF_CAUSE      8'h14
`define SCC_OFF_INT_STAT   8'h18
`define SCC_OFF_INT_CLR    8'h1c
`define SCC_OFF_INT_EN     8'h20

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define SCC_CTRL_GATE      0
`define SCC_CTRL_SLEEP     1
`define SCC_CTRL_SWRST     2
`define SCC_STATE_SLEEP    0
`define SCC_STATE_RST      1
`define SCC_CAUSE_SW       0
`define SCC_CAUSE_WDOG     1
`define SCC_CAUSE_BOR      2
`define SCC_CAUSE_POR      3
`define SCC_CAUSE_EXT      4
`define SCC_EV_WAKE        0
`define SCC_EV_FAULT       1
`define SCC_EV_DENIED      2

// ---------------------------------------------------------------
// widths, reset values and timing
// ---------------------------------------------------------------
`define SCC_CAUSE_W        5
`define SCC_EV_W           3
`define SCC_CAUSE_RESET    5'h08
`define SCC_CAUSE_EXT_ONLY 5'h10
`define SCC_EV_RESET       3'h0
`define SCC_CTRL_RESET     1'h0
`define SCC_NPERIPH        24
`define SCC_EN_DELAY       5
`define SCC_RST_PULSE      8

`endif

// File: design/scc_sync2.v
// two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/100ps
module scc_sync2 #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             i_clk,
  input  wire             i_reset_n,
  // async in, synced out
  input  wire [WIDTH-1:0] i_async,
  output reg  [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] meta_reg;

  // ---------------------------------------------------------------
  // the first stage feeds only the second
  // ---------------------------------------------------------------
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_reg <= {WIDTH{1'b0}};
      o_sync   <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end

endmodule

// File: design/scc_top.v
// sleep gating, device software reset and sticky reset cause control
`timescale 1ns/100ps
`include "scc_map.vh"
module scc_top #(
  parameter NPERIPH   = `SCC_NPERIPH,
  parameter EN_DELAY  = `SCC_EN_DELAY,
  parameter RST_PULSE = `SCC_RST_PULSE
) (
  // clock and reset
  input  wire               i_clk,
  input  wire               i_reset_n,
  // register port
  input  wire [7:0]         i_addr,
  input  wire [31:0]        i_wdata,
  input  wire               i_wr,
  input  wire               i_rd,
  output reg  [31:0]        o_rdata,
  // reset sources, asynchronous levels
  input  wire               i_wdog_reset,
  input  wire               i_brownout,
  input  wire               i_ext_reset_pin,
  // peripheral side, same clock
  input  wire [NPERIPH-1:0] i_periph_irq,
  input  wire               i_pacc_valid,
  input  wire [4:0]         i_pacc_idx,
  // core and peripheral control
  output reg                o_core_clk_en,
  output reg                o_core_sleeping,
  output reg  [NPERIPH-1:0] o_periph_clk_en,
  output reg                o_sys_reset_n,
  output reg                o_pacc_grant,
  output reg                o_bus_fault,
  output reg                o_irq
);

  localparam [2:0] DLY  = EN_DELAY;
  localparam [3:0] PULS = RST_PULSE;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  reg  [NPERIPH-1:0]      run_en_reg;
  reg  [NPERIPH-1:0]      run_en_next;
  reg  [NPERIPH-1:0]      sleep_en_reg;
  reg  [NPERIPH-1:0]      sleep_en_next;
  reg                     gate_reg;
  reg                     gate_next;
  reg                     sleep_reg;
  reg                     sleep_next;
  reg  [`SCC_CAUSE_W-1:0] cause_reg;
  reg  [`SCC_CAUSE_W-1:0] cause_next;
  reg  [`SCC_EV_W-1:0]    ev_reg;
  reg  [`SCC_EV_W-1:0]    ev_next;
  reg  [`SCC_EV_W-1:0]    ev_en_reg;
  reg  [`SCC_EV_W-1:0]    ev_en_next;
  reg  [3:0]              rst_cnt_reg;
  reg  [3:0]              rst_cnt_next;
  reg  [2:0]              src_last_reg;
  wire [2:0]              src_sync;
  wire [2:0]              src_rise;
  wire [NPERIPH-1:0]      ready;
  wire [NPERIPH-1:0]      pending;
  wire [NPERIPH-1:0]      clk_run;
  wire [NPERIPH-1:0]      clk_run_next;
  wire                    wake;
  wire                    soft_clr;
  wire                    dev_reset;
  reg                     pacc_ok;
  reg                     pacc_bad;
  reg                     pacc_off;
  reg  [31:0]             rdata_next;

  // ---------------------------------------------------------------
  // reset sources
  // ---------------------------------------------------------------
  // order: watchdog, brown-out, external pin
  scc_sync2 #(
    .WIDTH     (3)
  ) u_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_async   ({i_ext_reset_pin, i_brownout, i_wdog_reset}),
    .o_sync    (src_sync)
  );

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      src_last_reg <= 3'h0;
    end else begin
      src_last_reg <= src_sync;
    end
  end

  assign src_rise = src_sync & ~src_last_reg;

  // software reset request, any source that resets the whole device
  wire sw_req = i_wr && (i_addr == `SCC_OFF_CTRL) && i_wdata[`SCC_CTRL_SWRST];
  assign dev_reset = sw_req | (|src_rise);
  // registers other than the cause flags are held at defaults during the pulse
  assign soft_clr  = dev_reset | (rst_cnt_reg != 4'h0);

  // ---------------------------------------------------------------
  // device reset pulse
  // ---------------------------------------------------------------
  always @* begin
    rst_cnt_next = rst_cnt_reg;
    if (dev_reset) begin
      rst_cnt_next = PULS;
    end else if (rst_cnt_reg != 4'h0) begin
      rst_cnt_next = rst_cnt_reg - 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // per-peripheral enable delay
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NPERIPH; g = g + 1) begin : g_per
      reg [2:0] dly_reg;
      always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          dly_reg <= 3'h0;
        end else if (!run_en_next[g]) begin
          dly_reg <= 3'h0;
        end else if (!run_en_reg[g]) begin
          dly_reg <= DLY;
        end else if (dly_reg != 3'h0) begin
          dly_reg <= dly_reg - 3'h1;
        end
      end
      assign pending[g] = run_en_reg[g] && (dly_reg != 3'h0);
      assign ready[g]   = run_en_reg[g] && (dly_reg == 3'h0);
      // clock stays on in sleep if gating is off or the sleep enable is set
      assign clk_run[g] = run_en_reg[g] &&
                          (!sleep_reg || !gate_reg || sleep_en_reg[g]);
      // taken from next state so the clock enables line up with o_core_sleeping
      assign clk_run_next[g] = run_en_next[g] &&
                               (!sleep_next || !gate_next || sleep_en_next[g]);
    end
  endgenerate

  // a peripheral can only wake the core if its clock is running
  assign wake = sleep_reg && (|(i_periph_irq & clk_run));

  // ---------------------------------------------------------------
  // peripheral access check
  // ---------------------------------------------------------------
  always @* begin
    pacc_ok  = 1'b0;
    pacc_bad = 1'b0;
    pacc_off = 1'b0;
    if (i_pacc_valid) begin
      if (i_pacc_idx >= NPERIPH) begin
        pacc_off = 1'b1;
      end else if (ready[i_pacc_idx]) begin
        pacc_ok  = 1'b1;
      end else if (pending[i_pacc_idx]) begin
        pacc_bad = 1'b1;
      end else begin
        pacc_off = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // register writes and sleep control
  // ---------------------------------------------------------------
  always @* begin
    run_en_next   = run_en_reg;
    sleep_en_next = sleep_en_reg;
    gate_next     = gate_reg;
    sleep_next    = sleep_reg;
    ev_en_next    = ev_en_reg;
    if (soft_clr) begin
      run_en_next   = {NPERIPH{1'b0}};
      sleep_en_next = {NPERIPH{1'b0}};
      gate_next     = `SCC_CTRL_RESET;
      sleep_next    = 1'b0;
      ev_en_next    = `SCC_EV_RESET;
    end else begin
      if (i_wr) begin
        case (i_addr)
          `SCC_OFF_RUN_EN: begin
            run_en_next = i_wdata[NPERIPH-1:0];
          end
          `SCC_OFF_SLEEP_EN: begin
            // stored even while gating is off, only used once it is on
            sleep_en_next = i_wdata[NPERIPH-1:0];
          end
          `SCC_OFF_CTRL: begin
            gate_next = i_wdata[`SCC_CTRL_GATE];
            if (i_wdata[`SCC_CTRL_SLEEP]) begin
              sleep_next = 1'b1;
            end
          end
          `SCC_OFF_INT_EN: begin
            ev_en_next = i_wdata[`SCC_EV_W-1:0];
          end
          default: begin
          end
        endcase
      end
      // held asleep until a wake; a wake in the request cycle is ignored
      if (wake) begin
        sleep_next = 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // sticky cause flags
  // ---------------------------------------------------------------
  always @* begin
    cause_next = cause_reg;
    if (i_wr && (i_addr == `SCC_OFF_CAUSE)) begin
      cause_next = cause_reg & ~i_wdata[`SCC_CAUSE_W-1:0];
    end
    if (src_rise[2]) begin
      // an external reset wipes older causes
      cause_next = `SCC_CAUSE_EXT_ONLY;
    end else begin
      if (sw_req) begin
        cause_next[`SCC_CAUSE_SW] = 1'b1;
      end
      if (src_rise[0]) begin
        cause_next[`SCC_CAUSE_WDOG] = 1'b1;
      end
      if (src_rise[1]) begin
        cause_next[`SCC_CAUSE_BOR] = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt events, set wins over clear
  // ---------------------------------------------------------------
  always @* begin
    ev_next = ev_reg;
    if (soft_clr) begin
      ev_next = `SCC_EV_RESET;
    end else begin
      if (i_wr && (i_addr == `SCC_OFF_INT_CLR)) begin
        ev_next = ev_reg & ~i_wdata[`SCC_EV_W-1:0];
      end
      if (wake) begin
        ev_next[`SCC_EV_WAKE] = 1'b1;
      end
      if (pacc_bad) begin
        ev_next[`SCC_EV_FAULT] = 1'b1;
      end
      if (pacc_off) begin
        ev_next[`SCC_EV_DENIED] = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always @* begin
    rdata_next = 32'h0;
    if (i_rd) begin
      case (i_addr)
        `SCC_OFF_RUN_EN: begin
          rdata_next[NPERIPH-1:0] = run_en_reg;
        end
        `SCC_OFF_SLEEP_EN: begin
          rdata_next[NPERIPH-1:0] = sleep_en_reg;
        end
        `SCC_OFF_CTRL: begin
          rdata_next[`SCC_CTRL_GATE] = gate_reg;
        end
        `SCC_OFF_STATE: begin
          rdata_next[`SCC_STATE_SLEEP] = sleep_reg;
          rdata_next[`SCC_STATE_RST]   = (rst_cnt_reg != 4'h0);
        end
        `SCC_OFF_READY: begin
          rdata_next[NPERIPH-1:0] = ready;
        end
        `SCC_OFF_CAUSE: begin
          rdata_next[`SCC_CAUSE_W-1:0] = cause_reg;
        end
        `SCC_OFF_INT_STAT: begin
          rdata_next[`SCC_EV_W-1:0] = ev_reg;
        end
        `SCC_OFF_INT_EN: begin
          rdata_next[`SCC_EV_W-1:0] = ev_en_reg;
        end
        default: begin
          rdata_next = 32'h0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // flip-flops
  // ---------------------------------------------------------------
  // only the cause flags survive a device reset; power-on sets its flag
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cause_reg <= `SCC_CAUSE_RESET;
    end else begin
      cause_reg <= cause_next;
    end
  end

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      run_en_reg      <= {NPERIPH{1'b0}};
      sleep_en_reg    <= {NPERIPH{1'b0}};
      gate_reg        <= `SCC_CTRL_RESET;
      sleep_reg       <= 1'b0;
      ev_reg          <= `SCC_EV_RESET;
      ev_en_reg       <= `SCC_EV_RESET;
      rst_cnt_reg     <= 4'h0;
      o_rdata         <= 32'h0;
      o_core_clk_en   <= 1'b1;
      o_core_sleeping <= 1'b0;
      o_periph_clk_en <= {NPERIPH{1'b0}};
      o_sys_reset_n   <= 1'b0;
      o_pacc_grant    <= 1'b0;
      o_bus_fault     <= 1'b0;
      o_irq           <= 1'b0;
    end else begin
      run_en_reg      <= run_en_next;
      sleep_en_reg    <= sleep_en_next;
      gate_reg        <= gate_next;
      sleep_reg       <= sleep_next;
      ev_reg          <= ev_next;
      ev_en_reg       <= ev_en_next;
      rst_cnt_reg     <= rst_cnt_next;
      o_rdata         <= rdata_next;
      o_core_clk_en   <= !sleep_next;
      o_core_sleeping <= sleep_next;
      o_periph_clk_en <= clk_run_next & ~{NPERIPH{soft_clr}};
      o_sys_reset_n   <= !(|rst_cnt_next);
      o_pacc_grant    <= pacc_ok && !soft_clr;
      o_bus_fault     <= pacc_bad && !soft_clr;
      o_irq           <= |(ev_next & ev_en_next);
    end
  end

endmodule

// File: test/scc_core_model.sv
// processor core model: register reads, writes and peripheral accesses
`timescale 1ns/100ps
`include "scc_map.vh"
module scc_core_model (
  // clock and answers
  input  wire         i_clk,
  input  wire  [31:0] i_rdata,
  input  wire         i_grant,
  input  wire         i_fault,
  // requests
  output logic [7:0]  o_addr,
  output logic [31:0] o_wdata,
  output logic        o_wr,
  output logic        o_rd,
  output logic        o_valid,
  output logic [4:0]  o_idx
);
  initial begin
    o_addr  = 8'h00;
    o_wdata = 32'h0;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_valid = 1'b0;
    o_idx   = 5'h00;
  end
  // ----------------------------------------------------------------
  // bus cycles; idle address and data show the inverse so stale values never match
  // ----------------------------------------------------------------
  task automatic wr(input [7:0] a, input [31:0] w);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= w;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~w;
  endtask
  task automatic rd(input [7:0] a, output [31:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    #1 d = i_rdata;
  endtask
  // back-to-back accesses, one answer bit per access
  task automatic pacc_run(input [4:0] i, input int n, output [7:0] f, output [7:0] g);
    int j;
    f = 8'h00;
    g = 8'h00;
    @(posedge i_clk);
    o_idx   <= i;
    o_valid <= 1'b1;
    for (j = 0; j < n; j++) begin
      @(posedge i_clk);
      if (j == n - 1) begin
        o_valid <= 1'b0;
        o_idx   <= ~i;
      end
      #1 f[j] = i_fault;
      g[j] = i_grant;
    end
  endtask
  // software habit: read the flags, then clear exactly those seen
  task automatic clear_all(output [31:0] c);
    rd(`SCC_OFF_CAUSE, c);
    wr(`SCC_OFF_CAUSE, c);
  endtask
endmodule

// File: test/scc_top_asserts.sv
// port-level checks for the sleep and reset cause controller
`timescale 1ns/100ps
`include "scc_map.vh"
module scc_top_asserts #(
  parameter NPERIPH = 24
) (
  // clock and reset
  input wire               i_clk,
  input wire               i_reset_n,
  // register port
  input wire [7:0]         i_addr,
  input wire [31:0]        i_wdata,
  input wire               i_wr,
  input wire               i_rd,
  input wire [31:0]        o_rdata,
  // peripheral side and control
  input wire [NPERIPH-1:0] i_periph_irq,
  input wire               i_pacc_valid,
  input wire [4:0]         i_pacc_idx,
  input wire               o_core_clk_en,
  input wire               o_core_sleeping,
  input wire [NPERIPH-1:0] o_periph_clk_en,
  input wire               o_sys_reset_n,
  input wire               o_pacc_grant,
  input wire               o_bus_fault
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  wire        wake_w  = |(i_periph_irq & o_periph_clk_en);
  wire        sleep_w = i_wr && i_addr == `SCC_OFF_CTRL && i_wdata[`SCC_CTRL_SLEEP] &&
                        !i_wdata[`SCC_CTRL_SWRST];
  logic [3:0] cnt_reg;
  // cycles since the last enable write, saturating so it never wraps into the window
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_reg <= 4'hf;
    end else if (i_wr && i_addr == `SCC_OFF_RUN_EN) begin
      cnt_reg <= 4'h0;
    end else if (cnt_reg != 4'hf) begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
  sequence s_rst_low;
    !o_sys_reset_n [*8] ##1 o_sys_reset_n;
  endsequence
  sequence s_pclk_off;
    (o_periph_clk_en == '0) [*7];
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_RST_LEN: assert property ($fell(o_sys_reset_n) |-> s_rst_low)
    else $error("device reset pulse length wrong");
  AST_RST_CLKS: assert property ($fell(o_sys_reset_n) |=> s_pclk_off)
    else $error("peripheral clock on during device reset");
  AST_GRANT_SRC: assert property (o_pacc_grant |->
    $past(i_pacc_valid && i_pacc_idx < NPERIPH && o_periph_clk_en[i_pacc_idx]))
    else $error("grant without access to a clocked peripheral");
  AST_ONE_ANSWER: assert property (!(o_pacc_grant && o_bus_fault))
    else $error("grant and fault together");
  AST_FAULT_WIN: assert property (o_bus_fault |-> $past(i_pacc_valid) &&
    cnt_reg >= 4'h1 && cnt_reg <= 4'h5)
    else $error("fault outside the enable delay");
  AST_SLEEP_IN: assert property (sleep_w && o_sys_reset_n |=>
    o_core_sleeping && !o_core_clk_en)
    else $error("sleep request not taken");
  AST_WAKE: assert property (o_core_sleeping && wake_w |=>
    !o_core_sleeping && o_core_clk_en)
    else $error("interrupt of a running peripheral did not wake");
  AST_STAY: assert property (o_core_sleeping && !wake_w && !i_wr |=> o_core_sleeping)
    else $error("core left sleep without a wake");
  AST_CAUSE_RD: assert property (i_rd && i_addr == `SCC_OFF_CAUSE |=>
    o_rdata[31:5] == 27'h0)
    else $error("cause read has stray upper bits");
endmodule

// File: test/sleep_and_reset_cause_control_tb.sv
// testbench for the sleep and reset cause controller
`timescale 1ns/100ps
`include "scc_map.vh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module sleep_and_reset_cause_control_tb;
  logic        i_clk, i_reset_n, i_wr, i_rd, i_pacc_valid, i_wdog_reset, i_brownout;
  logic        i_ext_reset_pin, o_core_clk_en, o_core_sleeping, o_sys_reset_n;
  logic        o_pacc_grant, o_bus_fault, o_irq;
  logic [7:0]  i_addr, f, g;
  logic [31:0] i_wdata, o_rdata, d;
  logic [23:0] i_periph_irq, o_periph_clk_en;
  logic [4:0]  i_pacc_idx;
  int          error_cnt, tests_run, n;
  scc_top dut_u (.i_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_wdog_reset,
    .i_brownout, .i_ext_reset_pin, .i_periph_irq, .i_pacc_valid, .i_pacc_idx, .o_core_clk_en,
    .o_core_sleeping, .o_periph_clk_en, .o_sys_reset_n, .o_pacc_grant, .o_bus_fault, .o_irq);
  scc_core_model cpu_u (.i_clk, .i_rdata(o_rdata), .i_grant(o_pacc_grant),
    .i_fault(o_bus_fault), .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd),
    .o_valid(i_pacc_valid), .o_idx(i_pacc_idx));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic rd_chk(input [7:0] a, input [31:0] e, input string nm);
    cpu_u.rd(a, d);
    `CHK(nm, e, d)
  endtask
  // counts low cycles of the device reset; bounded so a stuck reset ends the run
  task automatic wait_rst(output int m);
    int k;
    m = 0;
    for (k = 0; k < 40 && (m == 0 || o_sys_reset_n !== 1'b1); k++) begin
      #1 if (o_sys_reset_n === 1'b0) m++;
      @(posedge i_clk);
    end
    if (k == 40) begin
      error_cnt++;
      $display("wrong value device reset exp done got hang");
      results();
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_por;
    rd_chk(`SCC_OFF_CAUSE, 32'h08, "cause");
    rd_chk(`SCC_OFF_RUN_EN, 32'h0, "run_en");
    rd_chk(8'h30, 32'h0, "unmapped");
    `CHK("pclk", 24'h0, o_periph_clk_en)
    $display("done por");
  endtask
  task automatic t_enable;
    cpu_u.pacc_run(5'd4, 1, f, g);
    `CHK("denied", 16'h0, {f, g})
    rd_chk(`SCC_OFF_INT_STAT, 32'h4, "stat_denied");
    cpu_u.wr(`SCC_OFF_RUN_EN, 32'h28);
    cpu_u.pacc_run(5'd3, 6, f, g);
    `CHK("fault", 8'h0f, f)
    `CHK("grant", 8'h30, g)
    rd_chk(`SCC_OFF_READY, 32'h28, "ready");
    rd_chk(`SCC_OFF_INT_STAT, 32'h6, "stat");
    `CHK("irq_masked", 1'b0, o_irq)
    cpu_u.wr(`SCC_OFF_INT_EN, 32'h4);
    @(posedge i_clk);
    #1 `CHK("irq_on", 1'b1, o_irq)
    cpu_u.wr(`SCC_OFF_INT_CLR, 32'h7);
    @(posedge i_clk);
    #1 `CHK("irq_off", 1'b0, o_irq)
    $display("done enable");
  endtask
  task automatic t_sleep;
    cpu_u.wr(`SCC_OFF_SLEEP_EN, 32'h08);
    cpu_u.wr(`SCC_OFF_INT_EN, 32'h1);
    cpu_u.wr(`SCC_OFF_CTRL, 32'h3);
    #1 `CHK("sleep", 2'b10, {o_core_sleeping, o_core_clk_en})
    `CHK("pclk_sleep", 24'h08, o_periph_clk_en)
    @(posedge i_clk) i_periph_irq <= 24'h20;
    repeat (3) @(posedge i_clk);
    #1 `CHK("stay", 1'b1, o_core_sleeping)
    @(posedge i_clk) i_periph_irq <= 24'h08;
    @(posedge i_clk);
    #1 `CHK("wake", 2'b01, {o_core_sleeping, o_core_clk_en})
    @(posedge i_clk) i_periph_irq <= 24'h0;
    #1 `CHK("wake_irq", 1'b1, o_irq)
    cpu_u.wr(`SCC_OFF_INT_CLR, 32'h1);
    cpu_u.wr(`SCC_OFF_CTRL, 32'h2);
    #1 `CHK("pclk_nogate", 24'h28, o_periph_clk_en)
    rd_chk(`SCC_OFF_SLEEP_EN, 32'h08, "sleep_kept");
    rd_chk(`SCC_OFF_STATE, 32'h1, "state_sleep");
    @(posedge i_clk) i_periph_irq <= 24'h20;
    @(posedge i_clk) i_periph_irq <= 24'h0;
    #1 `CHK("wake_nogate", 1'b0, o_core_sleeping)
    $display("done sleep");
  endtask
  task automatic t_swrst;
    cpu_u.wr(`SCC_OFF_CTRL, 32'h4);
    wait_rst(n);
    `CHK("rst_len", `SCC_RST_PULSE, n)
    rd_chk(`SCC_OFF_CAUSE, 32'h09, "cause_sw");
    rd_chk(`SCC_OFF_RUN_EN, 32'h0, "run_def");
    rd_chk(`SCC_OFF_SLEEP_EN, 32'h0, "sleep_def");
    rd_chk(`SCC_OFF_INT_EN, 32'h0, "int_en_def");
    cpu_u.wr(`SCC_OFF_CAUSE, 32'h01);
    rd_chk(`SCC_OFF_CAUSE, 32'h08, "cause_subset");
    $display("done software reset");
  endtask
  task automatic t_sources;
    @(posedge i_clk) i_wdog_reset <= 1'b1;
    wait_rst(n);
    rd_chk(`SCC_OFF_CAUSE, 32'h0a, "cause_wdog");
    @(posedge i_clk) i_wdog_reset <= 1'b0;
    i_brownout <= 1'b1;
    wait_rst(n);
    rd_chk(`SCC_OFF_CAUSE, 32'h0e, "cause_bor");
    @(posedge i_clk) i_brownout <= 1'b0;
    i_ext_reset_pin <= 1'b1;
    wait_rst(n);
    @(posedge i_clk) i_ext_reset_pin <= 1'b0;
    cpu_u.clear_all(d);
    `CHK("cause_ext", 32'h10, d)
    rd_chk(`SCC_OFF_CAUSE, 32'h0, "cause_clear");
    $display("done reset sources");
  endtask
  initial begin
    i_reset_n       = 1'b0;
    i_wdog_reset    = 1'b0;
    i_brownout      = 1'b0;
    i_ext_reset_pin = 1'b0;
    i_periph_irq    = 24'h0;
    error_cnt       = 0;
    tests_run       = 0;
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    t_por();
    t_enable();
    t_sleep();
    t_swrst();
    t_sources();
    results();
  end
endmodule
bind scc_top scc_top_asserts #(.NPERIPH(NPERIPH)) chk_u (.i_clk, .i_reset_n, .i_addr,
  .i_wdata, .i_wr, .i_rd, .o_rdata, .i_periph_irq, .i_pacc_valid, .i_pacc_idx,
  .o_core_clk_en, .o_core_sleeping, .o_periph_clk_en, .o_sys_reset_n, .o_pacc_grant,
  .o_bus_fault);
